// ---- hw/fbs_pkg.sv ----
// constants shared by the flash block service unit
package fbs_pkg;
  localparam logic [7:0] FBS_KEY_VALUE   = 8'h3a;
  localparam logic [7:0] FBS_PAR_BASE    = 8'hf8;
  localparam int         FBS_PAR_COUNT   = 7;
  localparam int         FBS_PAR_GUARD   = 0;
  localparam int         FBS_PAR_STACK   = 1;
  localparam int         FBS_PAR_BLOCK   = 2;
  localparam int         FBS_PAR_BUFFER  = 3;
  localparam int         FBS_PAR_DIVIDER = 4;
  localparam int         FBS_PAR_DELAY   = 6;
  localparam logic [7:0] FBS_ADDR_GUARD  = 8'hf8;
  localparam logic [7:0] FBS_ADDR_STACK  = 8'hf9;
  localparam logic [7:0] FBS_MERGE_SRC   = 8'h80;
  localparam logic [7:0] FBS_FN_BOOT     = 8'h00;
  localparam logic [7:0] FBS_FN_READ     = 8'h01;
  localparam logic [7:0] FBS_FN_PROGRAM  = 8'h02;
  localparam logic [7:0] FBS_FN_ERASE    = 8'h03;
  localparam logic [7:0] FBS_FN_MERGE    = 8'h04;
  localparam logic [7:0] FBS_RES_OK      = 8'h00;
  localparam logic [7:0] FBS_RES_PROT    = 8'h01;
  localparam logic [7:0] FBS_RES_FATAL   = 8'h03;
  localparam logic [1:0] FBS_LVL_READ    = 2'h1;
  localparam logic [1:0] FBS_LVL_FULL    = 2'h3;
  localparam logic [6:0] FBS_BLOCK_LAST  = 7'h3f;
  localparam logic [6:0] FBS_CAL_LO      = 7'h3e;
  localparam logic [6:0] FBS_CAL_HI      = 7'h3f;
  localparam logic [6:0] FBS_CAL_BASE    = 7'h40;
  localparam logic [7:0] FBS_ERASED_BYTE = 8'hff;
  localparam int         FBS_FLASH_AW    = 13;
  localparam int         FBS_AUX_AW      = 7;
endpackage : fbs_pkg

// ---- hw/fbs_byte_mem.sv ----
// byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module fbs_byte_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule : fbs_byte_mem
`default_nettype wire

// ---- hw/fbs_unit.sv ----
// flash block service sequencer
// Function
// - code 00h or hardware reset runs boot handoff, parameter block unused
// - bad guard or stack key with nonzero code halts the processor
// - boot handoff checks calibration data with a 16-bit checksum before release
// - block read copies 64 flash bytes into sram from buffer base
// - read protected block: read exits, accumulator and stack key zero, guard 01h
// - successful read leaves accumulator, guard key and stack key zero
// - block program moves 64 sram bytes from buffer base into selected block
// - write protected block: program exits with zeros and guard key 01h
// - program or erase hold length derives from the caller divider parameter
// - block erase clears one 64-byte block using divider and delay
// - write protected block: erase exits with zeros and guard key 01h
// - block erase leaves the block protection level unchanged
// - two-bit levels: 00 open, 01 read protect, 10 ext write, 11 int write
// - four levels per protection byte, lowest block in lowest bits
// - internal table-fetch reads are always allowed regardless of level
// - merge service ORs sram protection data from 80h into protection block
// - only the idle-time aux load port lowers protection; no service here reduces it
// - accumulator selects service; undefined code halts the processor
// - result in guard key: 00h success, 01h protection, 03h fatal
`timescale 1ns/1ps
`default_nettype none
module fbs_unit
  import fbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        call_strobe,
  input  wire logic [7:0]  call_code,
  input  wire logic [7:0]  stack_pointer,
  output logic             busy,
  output logic             done,
  output logic             halted,
  output logic             released,
  output logic             cal_error,
  output logic [7:0]       acc_result,
  output logic [7:0]       sram_addr,
  output logic [7:0]       sram_wdata,
  output logic             sram_we,
  output logic             sram_re,
  input  wire logic [7:0]  sram_rdata,
  input  wire logic        aux_load_we,
  input  wire logic [6:0]  aux_load_addr,
  input  wire logic [7:0]  aux_load_data,
  input  wire logic [12:0] fetch_addr,
  output logic [7:0]       fetch_data
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_PARAM, S_CHECK, S_PROT, S_READ, S_PROG, S_ERASE,
    S_MERGE, S_HOLD, S_RES0, S_RES1, S_BOOT, S_HALT
  } fbs_state_t;

  fbs_state_t  state_reg, state_next;
  logic [6:0]  cnt_reg;
  logic        ph_reg;
  logic [7:0]  code_reg;
  logic [7:0]  res_reg;
  logic        halt_pend_reg;
  logic        boot_pend_reg;
  logic [15:0] sum_reg;
  logic [7:0]  cal_lo_reg;
  logic [16:0] tmr_reg;
  logic        done_reg;
  logic        released_reg;
  logic        cal_error_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  par_reg [0:FBS_PAR_COUNT-1];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic [7:0]  blk       = par_reg[FBS_PAR_BLOCK];
  wire logic [7:0]  buf_base  = par_reg[FBS_PAR_BUFFER];
  wire logic [7:0]  cnt8      = {1'b0, cnt_reg};
  wire logic [12:0] blk_addr  = {blk[6:0], cnt_reg[5:0]};
  wire logic        last      = (cnt_reg == FBS_BLOCK_LAST);
  wire logic        keys_ok   = (par_reg[FBS_PAR_GUARD] == FBS_KEY_VALUE) &&
                                (par_reg[FBS_PAR_STACK] == stack_pointer);
  wire logic        code_ok   = (code_reg >= FBS_FN_READ) && (code_reg <= FBS_FN_MERGE);
  wire logic        go_call   = (state_reg == S_IDLE) && call_strobe && !boot_pend_reg;
  wire logic [7:0]  aux_rdata;
  wire logic [7:0]  flash_rdata;
  // two bits per block, lowest block in lowest bits
  wire logic [1:0]  level     = aux_rdata[{blk[1:0], 1'b0} +: 2];
  wire logic        rd_block  = (level == FBS_LVL_READ);
  wire logic        wr_block  = (level == FBS_LVL_FULL);
  // hold length grows with the divider, delay adds a fixed tail
  wire logic [16:0] hold_len  = {1'b0, par_reg[FBS_PAR_DIVIDER], 8'h00} +
                                {9'h000, par_reg[FBS_PAR_DELAY]};

  wire logic        flash_we    = (state_reg == S_PROG && ph_reg) ||
                                  (state_reg == S_ERASE);
  wire logic [7:0]  flash_wdata = (state_reg == S_ERASE) ? FBS_ERASED_BYTE : sram_rdata;
  wire logic        merge_we    = (state_reg == S_MERGE) && ph_reg;
  // protection writes come from the or-merge or the idle-time aux load port; the merge never drops a level
  wire logic [7:0]  merge_data  = aux_rdata | sram_rdata;
  wire logic        aux_we      = merge_we || (aux_load_we && state_reg == S_IDLE);
  wire logic [6:0]  aux_waddr   = merge_we ? cnt_reg : aux_load_addr;
  wire logic [7:0]  aux_wdata   = merge_we ? merge_data : aux_load_data;
  wire logic [6:0]  aux_raddr   = (state_reg == S_BOOT)  ? (FBS_CAL_BASE | cnt_reg) :
                                  (state_reg == S_MERGE) ? cnt_reg :
                                  {1'b0, blk[7:2]};
  wire logic [12:0] flash_raddr = (state_reg == S_READ) ? blk_addr : fetch_addr;

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  fbs_byte_mem #(.AW(FBS_FLASH_AW), .DW(8)) u_flash (
    .clk   (clk),
    .we    (flash_we),
    .waddr (blk_addr),
    .wdata (flash_wdata),
    .raddr (flash_raddr),
    .rdata (flash_rdata)
  );

  // protection block in the low half, calibration block in the high half
  fbs_byte_mem #(.AW(FBS_AUX_AW), .DW(8)) u_aux (
    .clk   (clk),
    .we    (aux_we),
    .waddr (aux_waddr),
    .wdata (aux_wdata),
    .raddr (aux_raddr),
    .rdata (aux_rdata)
  );

  // table fetch shares the flash read port and ignores levels; a fetch
  // during a block read sees the block data instead
  assign fetch_data = flash_rdata;

  // ---------------------------------------------------------------
  // sram port
  // ---------------------------------------------------------------
  always_comb begin
    sram_addr  = 8'h00;
    sram_wdata = 8'h00;
    sram_we    = 1'b0;
    sram_re    = 1'b0;
    unique case (state_reg)
      S_PARAM: begin
        sram_addr = FBS_PAR_BASE + cnt8;
        sram_re   = !ph_reg;
      end
      S_READ: begin
        sram_addr  = buf_base + cnt8;
        sram_wdata = flash_rdata;
        sram_we    = ph_reg;
      end
      S_PROG: begin
        sram_addr = buf_base + cnt8;
        sram_re   = !ph_reg;
      end
      S_MERGE: begin
        sram_addr = FBS_MERGE_SRC + cnt8;
        sram_re   = !ph_reg;
      end
      S_RES0: begin
        sram_addr  = FBS_ADDR_GUARD;
        sram_wdata = res_reg;
        sram_we    = 1'b1;
      end
      S_RES1: begin
        sram_addr  = FBS_ADDR_STACK;
        sram_wdata = 8'h00;
        sram_we    = 1'b1;
      end
      default: begin
        sram_addr = 8'h00;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:  if (boot_pend_reg) begin
                 state_next = S_BOOT;
               end else if (call_strobe) begin
                 state_next = (call_code == FBS_FN_BOOT) ? S_BOOT : S_PARAM;
               end
      S_PARAM: if (ph_reg && cnt_reg == 7'(FBS_PAR_COUNT - 1)) begin
                 state_next = S_CHECK;
               end
      S_CHECK: if (!keys_ok || !code_ok) begin
                 state_next = S_RES0;
               end else if (code_reg == FBS_FN_MERGE) begin
                 state_next = S_MERGE;
               end else begin
                 state_next = S_PROT;
               end
      S_PROT:  if (ph_reg) begin
                 if ((code_reg == FBS_FN_READ && rd_block) ||
                     (code_reg != FBS_FN_READ && wr_block)) begin
                   state_next = S_RES0;
                 end else begin
                   state_next = (code_reg == FBS_FN_READ)    ? S_READ :
                                (code_reg == FBS_FN_PROGRAM) ? S_PROG : S_ERASE;
                 end
               end
      S_READ:  if (ph_reg && last) begin
                 state_next = S_RES0;
               end
      S_PROG,
      S_MERGE: if (ph_reg && last) begin
                 state_next = S_HOLD;
               end
      S_ERASE: if (last) begin
                 state_next = S_HOLD;
               end
      S_HOLD:  if (tmr_reg == 17'h00000) begin
                 state_next = S_RES0;
               end
      S_RES0:  state_next = S_RES1;
      S_RES1:  state_next = halt_pend_reg ? S_HALT : S_IDLE;
      S_BOOT:  if (ph_reg && last && sum_reg == {aux_rdata, cal_lo_reg}) begin
                 state_next = S_IDLE;
               end else if (ph_reg && last) begin
                 // an unknown or wrong sum never releases
                 state_next = S_HALT;
               end
      S_HALT:  state_next = S_HALT;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 7'h00;
      ph_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 7'h00;
        ph_reg  <= 1'b0;
      end else if (state_reg == S_ERASE || ph_reg) begin
        cnt_reg <= cnt_reg + 7'h01;
        ph_reg  <= 1'b0;
      end else begin
        ph_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_reg      <= 8'h00;
      res_reg       <= 8'h00;
      halt_pend_reg <= 1'b0;
      boot_pend_reg <= 1'b1;
      tmr_reg       <= 17'h00000;
      acc_reg       <= 8'h00;
    end else begin
      if (state_reg == S_BOOT) begin
        boot_pend_reg <= 1'b0;
      end
      if (go_call) begin
        code_reg      <= call_code;
        res_reg       <= FBS_RES_OK;
        halt_pend_reg <= 1'b0;
      end
      if (state_reg == S_CHECK && (!keys_ok || !code_ok)) begin
        res_reg       <= FBS_RES_FATAL;
        halt_pend_reg <= 1'b1;
      end
      if (state_reg == S_PROT && ph_reg && state_next == S_RES0) begin
        res_reg <= FBS_RES_PROT;
      end
      if (state_reg != S_HOLD) begin
        tmr_reg <= hold_len;
      end else if (tmr_reg != 17'h00000) begin
        tmr_reg <= tmr_reg - 17'h00001;
      end
      if (state_reg == S_RES1) begin
        acc_reg <= 8'h00;
      end else if (go_call) begin
        acc_reg <= call_code;
      end
    end
  end

  for (genvar i = 0; i < FBS_PAR_COUNT; i++) begin : g_par
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        par_reg[i] <= 8'h00;
      end else if (state_reg == S_PARAM && ph_reg && cnt_reg == 7'(i)) begin
        par_reg[i] <= sram_rdata;
      end
    end
  end

  // calibration: bytes 0..61 summed, bytes 62/63 hold the expected value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sum_reg       <= 16'h0000;
      cal_lo_reg    <= 8'h00;
      released_reg  <= 1'b0;
      cal_error_reg <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      done_reg <= (state_reg == S_RES1) ||
                  (state_reg == S_BOOT && state_next == S_IDLE);
      if (state_reg != S_BOOT) begin
        sum_reg <= 16'h0000;
      end else if (ph_reg && cnt_reg < FBS_CAL_LO) begin
        sum_reg <= sum_reg + {8'h00, aux_rdata};
      end
      if (state_reg == S_BOOT && ph_reg && cnt_reg == FBS_CAL_LO) begin
        cal_lo_reg <= aux_rdata;
      end
      if (state_reg == S_BOOT && state_next == S_IDLE) begin
        released_reg <= 1'b1;
      end else if (state_reg == S_BOOT && state_next == S_HALT) begin
        cal_error_reg <= 1'b1;
        released_reg  <= 1'b0;
      end
    end
  end

  assign busy       = (state_reg != S_IDLE) && (state_reg != S_HALT);
  assign done       = done_reg;
  assign halted     = (state_reg == S_HALT);
  assign released   = released_reg;
  assign cal_error  = cal_error_reg;
  assign acc_result = acc_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_bad_check;
    state_reg == S_CHECK && !keys_ok;
  endsequence
  sequence s_fatal_out;
    sram_we && sram_addr == FBS_ADDR_GUARD && sram_wdata == FBS_RES_FATAL ##2 halted;
  endsequence

  a_bad_key_halt: assert property (s_bad_check |=> s_fatal_out)
    else $error("bad key did not halt with fatal code");
  a_refused_code: assert property (state_reg == S_PROT && ph_reg && state_next == S_RES0
      |=> sram_we && sram_wdata == FBS_RES_PROT)
    else $error("protection refusal not reported");
  a_stack_cleared: assert property (state_reg == S_RES0 |=> sram_we &&
      sram_addr == FBS_ADDR_STACK && sram_wdata == 8'h00 ##1 acc_reg == 8'h00)
    else $error("stack key or accumulator not cleared");
  a_read_count: assert property ($rose(state_reg == S_READ) |-> ##127 sram_we
      ##1 state_reg == S_RES0)
    else $error("block read did not copy 64 bytes");
  a_hold_len: assert property ($rose(state_reg == S_HOLD) |->
      tmr_reg == $past(hold_len))
    else $error("hold length not taken from divider");
  a_merge_or: assert property (merge_we |-> (aux_wdata & aux_rdata) == aux_rdata)
    else $error("protection level lowered");
  a_erase_prot: assert property (state_reg == S_ERASE |-> !aux_we)
    else $error("erase touched protection data");
  a_boot_reset: assert property ($rose(resetn) |-> ##[1:2] state_reg == S_BOOT)
    else $error("boot handoff not entered after reset");
  a_boot_release: assert property ($rose(released) |-> $past(state_reg) == S_BOOT &&
      $past(sum_reg) == {$past(aux_rdata), cal_lo_reg})
    else $error("release without checksum match");
endmodule : fbs_unit
`default_nettype wire

// ---- tb/fbs_sram_model.sv ----
// behavioural processor sram answering the unit's parameter and buffer accesses
`timescale 1ns/1ps
`default_nettype none
module fbs_sram_model (
  input  wire logic       clk,
  input  wire logic [7:0] sram_addr,
  input  wire logic [7:0] sram_wdata,
  input  wire logic       sram_we,
  input  wire logic       sram_re,
  output logic      [7:0] sram_rdata
);
  // ----------------------------------------
  // storage, also loaded by the bench as firmware
  // ----------------------------------------
  logic [7:0] mem [256];
  int         wr_count = 0;
  initial sram_rdata = 8'h00;
  always @(posedge clk) begin
    if (sram_we) begin
      mem[sram_addr] <= sram_wdata;
      wr_count <= wr_count + 1;
    end
    // no read: toggle so a stale byte never looks valid
    if (sram_re) sram_rdata <= mem[sram_addr];
    else sram_rdata <= ~sram_rdata;
  end
endmodule : fbs_sram_model
`default_nettype wire

// ---- tb/tb_flash_block_service_unit.sv ----
// self-checking bench for the flash block service sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_flash_block_service_unit;
  import fbs_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk = 1'b0, resetn = 1'b0, call_strobe = 1'b0;
  logic [7:0]  call_code = 8'h00, stack_pointer = 8'h42;
  logic        busy, done, halted, released, cal_error, sram_we, sram_re, aux_load_we = 1'b0;
  logic [7:0]  acc_result, sram_addr, sram_wdata, sram_rdata, fetch_data;
  logic [6:0]  aux_load_addr = 7'h00;
  logic [7:0]  aux_load_data = 8'h00;
  logic [12:0] fetch_addr = 13'h0000;
  int          miscompares = 0, checks_done = 0, cycles = 0, wr_before;
  logic [15:0] cal_sum;
  always #2.5 clk = ~clk;
  fbs_unit DUT (.clk(clk), .resetn(resetn), .call_strobe(call_strobe), .call_code(call_code),
    .stack_pointer(stack_pointer), .busy(busy), .done(done), .halted(halted),
    .released(released), .cal_error(cal_error), .acc_result(acc_result),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_we(sram_we), .sram_re(sram_re),
    .sram_rdata(sram_rdata), .aux_load_we(aux_load_we), .aux_load_addr(aux_load_addr),
    .aux_load_data(aux_load_data), .fetch_addr(fetch_addr), .fetch_data(fetch_data));
  fbs_sram_model ram (.clk(clk), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .sram_we(sram_we), .sram_re(sram_re), .sram_rdata(sram_rdata));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_end;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1 || halted === 1'b1) return;
    end
    chk("completion", 8'h01, 8'h00);
  endtask : wait_end
  // aux contents are loaded while reset holds the unit idle
  task automatic do_reset(input bit load, input bit bad_sum);
    @(posedge clk);
    resetn <= 1'b0;
    cal_sum = 16'h0000;
    for (int i = 0; i < 128 && load; i++) begin
      aux_load_we   <= 1'b1;
      aux_load_addr <= i[6:0];
      // levels: blk0 00, blk1 01, blk2 11, blk3 10, rest open
      if (i == 0) aux_load_data <= 8'hb4;
      else if (i < 64) aux_load_data <= 8'h00;
      else if (i < 126) aux_load_data <= i[7:0] + 8'h11;
      else if (i == 126) aux_load_data <= cal_sum[7:0];
      else aux_load_data <= cal_sum[15:8] ^ {7'h00, bad_sum};
      if (i >= 64 && i < 126) cal_sum = cal_sum + 16'(i[7:0] + 8'h11);
      @(posedge clk);
    end
    aux_load_we <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wait_end();
  endtask : do_reset
  // firmware side: fixed guard key, stack key matching the presented pointer only when good_key is set
  task automatic call(input logic [7:0] code, input logic [7:0] blk, input logic [7:0] buf_base,
                      input bit good_key);
    ram.mem[8'hf8] = FBS_KEY_VALUE;
    ram.mem[8'hf9] = good_key ? 8'h42 : 8'h41;
    ram.mem[8'hfa] = blk;
    ram.mem[8'hfb] = buf_base;
    ram.mem[8'hfc] = 8'h00;
    ram.mem[8'hfd] = 8'h00;
    ram.mem[8'hfe] = 8'h56;
    @(posedge clk);
    call_code   <= code;
    call_strobe <= 1'b1;
    @(posedge clk);
    call_strobe <= 1'b0;
    wait_end();
  endtask : call
  task automatic result(input logic [7:0] code);
    chk("guard key", code, ram.mem[FBS_ADDR_GUARD]);
    chk("stack key", 8'h00, ram.mem[FBS_ADDR_STACK]);
    chk("accumulator", 8'h00, acc_result);
  endtask : result
  task automatic fetch(input logic [12:0] a, input logic [7:0] exp);
    @(posedge clk);
    fetch_addr <= a;
    @(posedge clk);
    #1;
    chk("fetched byte", exp, fetch_data);
  endtask : fetch
  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      summarize();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wait_end();
    do_reset(1'b1, 1'b0);
    chk("released", 8'h01, {7'h00, released});
    chk("cal error", 8'h00, {7'h00, cal_error});
    wr_before = ram.wr_count;
    call(FBS_FN_BOOT, 8'h00, 8'h00, 1'b0);
    chk("boot sram writes", 8'h00, 8'(ram.wr_count - wr_before));
    chk("released", 8'h01, {7'h00, released});
    for (int i = 0; i < 64; i++) ram.mem[8'h10 + i] = i[7:0] ^ 8'h5a;
    call(FBS_FN_PROGRAM, 8'h05, 8'h10, 1'b1);
    result(FBS_RES_OK);
    for (int i = 0; i < 64; i++) fetch(13'(5 * 64 + i), i[7:0] ^ 8'h5a);
    call(FBS_FN_READ, 8'h05, 8'h40, 1'b1);
    result(FBS_RES_OK);
    for (int i = 0; i < 64; i++) chk("read copy", i[7:0] ^ 8'h5a, ram.mem[8'h40 + i]);
    call(FBS_FN_PROGRAM, 8'h03, 8'h10, 1'b1);
    result(FBS_RES_OK);
    call(FBS_FN_READ, 8'h01, 8'h40, 1'b1);
    result(FBS_RES_PROT);
    call(FBS_FN_PROGRAM, 8'h02, 8'h10, 1'b1);
    result(FBS_RES_PROT);
    call(FBS_FN_ERASE, 8'h02, 8'h00, 1'b1);
    result(FBS_RES_PROT);
    call(FBS_FN_ERASE, 8'h05, 8'h00, 1'b1);
    result(FBS_RES_OK);
    for (int i = 0; i < 64; i++) fetch(13'(5 * 64 + i), FBS_ERASED_BYTE);
    for (int i = 0; i < 64; i++) ram.mem[8'h10 + i] = 8'h00;
    call(FBS_FN_PROGRAM, 8'h05, 8'h10, 1'b1);
    result(FBS_RES_OK);
    for (int i = 0; i < 8; i++) fetch(13'(5 * 64 + i * 9), 8'h00);
    call(FBS_FN_ERASE, 8'h01, 8'h00, 1'b1);
    call(FBS_FN_READ, 8'h01, 8'h40, 1'b1);
    result(FBS_RES_PROT);
    // merge: block 4 gains read protect, zero bytes must not open block 1
    for (int i = 0; i < 64; i++) ram.mem[FBS_MERGE_SRC + i] = (i == 1) ? 8'h01 : 8'h00;
    call(FBS_FN_MERGE, 8'h00, 8'h00, 1'b1);
    result(FBS_RES_OK);
    call(FBS_FN_READ, 8'h04, 8'h40, 1'b1);
    result(FBS_RES_PROT);
    call(FBS_FN_READ, 8'h01, 8'h40, 1'b1);
    result(FBS_RES_PROT);
    call(FBS_FN_READ, 8'h05, 8'h40, 1'b0);
    chk("guard key", FBS_RES_FATAL, ram.mem[FBS_ADDR_GUARD]);
    chk("halted", 8'h01, {7'h00, halted});
    do_reset(1'b0, 1'b0);
    call(8'h09, 8'h05, 8'h40, 1'b1);
    chk("guard key", FBS_RES_FATAL, ram.mem[FBS_ADDR_GUARD]);
    chk("halted", 8'h01, {7'h00, halted});
    // corrupted checksum: boot must hold the processor
    do_reset(1'b1, 1'b1);
    chk("cal error", 8'h01, {7'h00, cal_error});
    chk("released", 8'h00, {7'h00, released});
    chk("halted", 8'h01, {7'h00, halted});
    summarize();
  end
endmodule : tb_flash_block_service_unit
`default_nettype wire
